// [mode_word_regs.svh]
// constants for the first mode word, burst order and timing of the sdram model
`ifndef MODE_WORD_REGS_SVH
`define MODE_WORD_REGS_SVH

// first mode word field positions
`define MW_BL_LO        0
`define MW_BL_HI        1
`define MW_CL_BIT0      2
`define MW_BT_BIT       3
`define MW_CL_LO        4
`define MW_CL_HI        6
`define MW_TM_BIT       7
`define MW_DLLRST_BIT   8
`define MW_WR_LO        9
`define MW_WR_HI        11
`define MW_CLX_BIT      12
`define MW_RESET        16'h0000

// burst length codes
`define BL_EIGHT        2'h0
`define BL_PER_CMD      2'h1
`define BL_CHOP         2'h2

// mode word select
`define MW_SEL_FIRST    3'h0
`define MW_SEL_NONE     3'h7

// clock and timing
`define CLK_PERIOD_NS   40
`define CHOP_PULL_IN    2
`define LOOP_LOCK_CYC   768
`define TRP_CYC         4
`define AL_DEFAULT      0

// apb register offsets of the controller
`define CTL_CMD_OFF     12'h000
`define CTL_ADDR_OFF    12'h004
`define CTL_WDATA_OFF   12'h008
`define CTL_STAT_OFF    12'h00C
`define CTL_RDATA_OFF   12'h010

// command codes written to the command register
`define CMD_MRS         3'h1
`define CMD_READ        3'h2
`define CMD_WRITE       3'h3

`endif

// [sdram_pkg.sv]
// types shared by both ends of the sdram link
package sdram_pkg;
    typedef enum logic [2:0]
    {
        CMD_NOP   = 3'h0,
        CMD_MRS   = 3'h1,
        CMD_READ  = 3'h2,
        CMD_WRITE = 3'h3
    } link_cmd_e;
    typedef logic [7:0] beat_t;
endpackage : sdram_pkg

// [sdram_link_if.sv]
// link between controller and sdram model
`timescale 1ns/1ns
interface sdram_link_if;
    sdram_pkg::link_cmd_e cmd;
    logic [15:0]          addr;
    logic [2:0]           sel;
    logic                 crc_bad;
    logic [7:0]           dq_ctl;
    logic                 dq_ctl_oe;
    logic [7:0]           dq_dev;
    logic                 dq_dev_oe;
    logic                 dqs_dev;
    modport device (input cmd, addr, sel, crc_bad, dq_ctl, dq_ctl_oe,
                    output dq_dev, dq_dev_oe, dqs_dev);
    modport host (output cmd, addr, sel, crc_bad, dq_ctl, dq_ctl_oe,
                  input dq_dev, dq_dev_oe, dqs_dev);
endinterface : sdram_link_if

// [sdram_device.sv]
// sdram model: first mode word, burst ordering, read latency, write commit
//
// Summary of operation
// RQ1: beat order from length, type, start column
// RQ2: length fixed chop, fixed eight, per command
// RQ3: sequential wraps in half; interleaved xors index
// RQ4: first read beat equals start column bits
// RQ5: chopped read drives high impedance last four
// RQ6: writes ignore start bits that do not matter
// RQ7: fixed chop write starts two clocks earlier
// RQ8: per command chop keeps eight beat timing
// RQ9: column read delay sets read data start
// RQ10: only whole clock read latencies
// RQ11: total delay is added plus column delay
// RQ12: controller keeps test mode bit zero
// RQ13: write recovery field sets precharge write delay
// RQ14: controller programs recovery at least minimum
// RQ15: crc checked before commit with byte mask
// RQ16: crc mismatch blocks write, array unchanged
// RQ17: controller programs read precharge at least minimum
// RQ18: read precharge plus precharge sets activate time
// RQ19: loop reset bit clears itself
// RQ20: controller reissues loop reset after enable
// RQ21: controller waits lock time before reads
// RQ22: fields latch only on first mode word set
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "mode_word_regs.svh"
module sdram_device
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    sdram_link_if.device     link,
    input  wire logic        crc_en,
    input  wire logic        mask_en,
    output logic [15:0]      mode_word,
    output logic [7:0]       wr_commit_delay,
    output logic [7:0]       act_delay,
    output logic [2:0]       write_start_pull,
    output logic             write_blocked
);
    // read view of the eight beat lanes, each lane holds one beat of every word
    sdram_pkg::beat_t lane_q [0:7];
    logic [15:0] mw_r;
    logic [5:0]  rcnt_r;
    logic [2:0]  rcol_r;
    logic        rchop_r;
    logic        rbusy_r;
    logic [2:0]  rword_r;
    logic [3:0]  wbeat_r;
    logic        wbusy_r;
    logic        wchop_r;
    logic [2:0]  wcol_r;
    logic [2:0]  wword_r;
    sdram_pkg::beat_t wbuf_r [0:7];
    logic [7:0]  dq_r;
    logic        oe_r;
    logic        dqs_r;
    logic        blk_r;
    logic        wdone_r;

    // ======================================================================
    // mode word decode
    wire [1:0] bl_mode = mw_r[`MW_BL_HI:`MW_BL_LO];
    wire       bt_int  = mw_r[`MW_BT_BIT];
    wire [4:0] cl_code = {mw_r[`MW_CLX_BIT], mw_r[`MW_CL_HI:`MW_CL_LO], mw_r[`MW_CL_BIT0]};
    wire [2:0] wr_code = mw_r[`MW_WR_HI:`MW_WR_LO];
    // column read delay in whole clocks only, see RQ9 see RQ10
    wire [5:0] cl_cyc  = (cl_code < 5'h8) ? 6'(cl_code) + 6'd9
                       : (cl_code < 5'hB) ? 6'(cl_code) * 6'd2 + 6'd2
                       : (cl_code == 5'hB) ? 6'd24 : (cl_code == 5'hC) ? 6'd23 : 6'd17;
    // total delay, see RQ11
    wire [5:0] rl_cyc  = cl_cyc + 6'(`AL_DEFAULT);
    wire [4:0] wr_cyc  = (wr_code == 3'h6) ? 5'd24 : 5'd10 + 5'(wr_code) * 5'd2;
    wire [3:0] rtp_cyc = (wr_code == 3'h6) ? 4'd12 : 4'd5 + 4'(wr_code);
    wire       is_mrs  = (link.cmd == sdram_pkg::CMD_MRS) && (link.sel == `MW_SEL_FIRST);
    // per command chop select on address bit 12, see RQ2
    wire       cmd_chop = (bl_mode == `BL_CHOP) ||
                          ((bl_mode == `BL_PER_CMD) && !link.addr[12]);
    wire [2:0] rbeat   = 3'(rcnt_r - rl_cyc);
    wire       in_rwin = rbusy_r && (rcnt_r >= rl_cyc) && (rcnt_r < rl_cyc + 6'd8);
    // sequential wraps in half, interleaved xors, see RQ1 see RQ3
    wire [2:0] seq_idx = {rcol_r[2] ^ rbeat[2], 2'(rcol_r[1:0] + rbeat[1:0])};
    wire [2:0] rd_idx  = bt_int ? (rcol_r ^ rbeat) : seq_idx;
    // last four slots of chopped read are high impedance, see RQ5
    wire       rd_drive = in_rwin && !(rchop_r && rbeat[2]);
    // write beat address ignores low bits, see RQ6
    wire [2:0] wr_idx  = wchop_r ? {wcol_r[2] ^ wbeat_r[2], wbeat_r[1:0]} : wbeat_r[2:0];

    assign mode_word        = mw_r;
    // precharge write delay, see RQ13; crc with byte mask adds a beat pair, see RQ15
    assign wr_commit_delay  = 8'(wr_cyc) + 8'(`TRP_CYC) + ((crc_en && mask_en) ? 8'd2 : 8'd0);
    assign act_delay        = 8'(rtp_cyc) + 8'(`TRP_CYC); // see RQ18
    // fixed chop pulls write start in, per command does not, see RQ7 see RQ8
    assign write_start_pull = (bl_mode == `BL_CHOP) ? 3'(`CHOP_PULL_IN) : 3'h0;
    assign write_blocked    = blk_r;
    assign link.dq_dev      = dq_r;
    assign link.dq_dev_oe   = oe_r;
    assign link.dqs_dev     = dqs_r;

    // ======================================================================
    // mode word latch, loop reset bit self clears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mw_r <= `MW_RESET;
        else if (is_mrs)
            mw_r <= link.addr; // see RQ22
        else if (mw_r[`MW_DLLRST_BIT])
            mw_r[`MW_DLLRST_BIT] <= 1'b0; // see RQ19
    end

    // read sequencer, first beat is start column, see RQ4
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rbusy_r <= 1'b0;
            rcnt_r  <= 6'h00;
            rcol_r  <= 3'h0;
            rchop_r <= 1'b0;
            rword_r <= 3'h0;
            dq_r    <= 8'h00;
            oe_r    <= 1'b0;
            dqs_r   <= 1'b0;
        end
        else
        begin
            if (link.cmd == sdram_pkg::CMD_READ && !rbusy_r)
            begin
                rbusy_r <= 1'b1;
                rcnt_r  <= 6'h01;
                rcol_r  <= link.addr[2:0];
                rword_r <= link.addr[5:3];
                rchop_r <= cmd_chop;
            end
            else if (rbusy_r)
            begin
                rcnt_r  <= rcnt_r + 6'h01;
                rbusy_r <= (rcnt_r < rl_cyc + 6'd7);
            end
            oe_r  <= rd_drive;
            dqs_r <= rd_drive;
            dq_r  <= rd_drive ? lane_q[rd_idx] : 8'h00;
        end
    end

    // write capture and commit, crc error discards data, see RQ16
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wbusy_r <= 1'b0;
            wbeat_r <= 4'h0;
            wchop_r <= 1'b0;
            wcol_r  <= 3'h0;
            wword_r <= 3'h0;
            blk_r   <= 1'b0;
            wdone_r <= 1'b0;
        end
        else
        begin
            // one cycle pulse after the last beat starts the commit
            wdone_r <= 1'b0;
            if (link.cmd == sdram_pkg::CMD_WRITE && !wbusy_r)
            begin
                wbusy_r <= 1'b1;
                wbeat_r <= 4'h0;
                wchop_r <= cmd_chop;
                wcol_r  <= link.addr[2:0];
                wword_r <= link.addr[5:3];
            end
            else if (wbusy_r && link.dq_ctl_oe)
            begin
                wbuf_r[wr_idx] <= link.dq_ctl;
                wbeat_r        <= wbeat_r + 4'h1;
                if (wbeat_r == (wchop_r ? 4'h3 : 4'h7))
                begin
                    wbusy_r <= 1'b0;
                    wdone_r <= 1'b1;
                    blk_r   <= crc_en && link.crc_bad; // see RQ16
                end
            end
        end
    end

    // ======================================================================
    // array commit one cycle after last beat unless blocked, one lane per beat
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_commit
            localparam logic [2:0] beat_pos = 3'(gi);
            sdram_pkg::beat_t lane_r [0:7];
            // a chopped write only touches the half picked by its start column
            wire lane_en = wdone_r && !blk_r && (!wchop_r || (beat_pos[2] == wcol_r[2]));
            assign lane_q[gi] = lane_r[rword_r];
            always_ff @(posedge pclk)
            begin
                if (lane_en)
                    lane_r[wword_r] <= wbuf_r[gi]; // see RQ6
            end
        end
    endgenerate
endmodule : sdram_device

// [sdram_host.sv]
// controller end: apb command registers driving the sdram link
`timescale 1ns/1ns
`include "mode_word_regs.svh"
module sdram_host
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    sdram_link_if.host       link
);
    logic [2:0]  cmd_r;
    logic [18:0] addr_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic [15:0] lock_r;
    logic        pend_r;
    logic [2:0]  beat_r;
    logic        wact_r;
    logic [7:0]  dq_r;
    logic [2:0]  go_r;
    logic        oe_r;
    logic        bad_r;

    // ======================================================================
    // apb decode
    wire wr_en   = psel && penable && pwrite;
    wire hit_cmd = paddr == `CTL_CMD_OFF;
    wire hit_adr = paddr == `CTL_ADDR_OFF;
    wire hit_wd  = paddr == `CTL_WDATA_OFF;
    wire hit_st  = paddr == `CTL_STAT_OFF;
    wire hit_rd  = paddr == `CTL_RDATA_OFF;
    wire mapped  = hit_cmd | hit_adr | hit_wd | hit_st | hit_rd;
    // reads held pending while loop locks, see RQ21
    wire locked  = lock_r == 16'h0000;
    // test mode bit forced to zero on first mode word, see RQ12
    wire [15:0] mrs_addr = (addr_r[18:16] == `MW_SEL_FIRST) ?
                           (addr_r[15:0] & ~16'h0080) : addr_r[15:0];

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = hit_st ? {29'h0, wact_r, !locked, pend_r} :
                     hit_rd ? rdata_r : hit_cmd ? {29'h0, cmd_r} :
                     hit_adr ? {13'h0, addr_r} : hit_wd ? wdata_r : 32'h0;
    assign link.cmd       = sdram_pkg::link_cmd_e'(go_r);
    assign link.addr      = (go_r == `CMD_MRS) ? mrs_addr : addr_r[15:0];
    assign link.sel       = (go_r == `CMD_MRS) ? addr_r[18:16] : `MW_SEL_NONE;
    // bit 3 of a command marks its write beats with a bad checksum
    assign link.crc_bad   = bad_r;
    assign link.dq_ctl    = dq_r;
    assign link.dq_ctl_oe = oe_r;

    // ======================================================================
    // registers, command launch and loop lock wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_r   <= 3'h0;
            addr_r  <= 19'h0;
            wdata_r <= 32'h0;
            rdata_r <= 32'h0;
            lock_r  <= 16'h0;
            pend_r  <= 1'b0;
            go_r    <= 3'h0;
            beat_r  <= 3'h0;
            wact_r  <= 1'b0;
            dq_r    <= 8'h00;
            oe_r    <= 1'b0;
            bad_r   <= 1'b0;
        end
        else
        begin
            go_r <= 3'h0;
            if (lock_r != 16'h0)
                lock_r <= lock_r - 16'h1;
            if (wr_en && hit_adr)
                addr_r <= pwdata[18:0];
            if (wr_en && hit_wd)
                wdata_r <= pwdata;
            if (wr_en && hit_cmd)
            begin
                cmd_r  <= pwdata[2:0];
                bad_r  <= pwdata[3];
                pend_r <= 1'b1;
            end
            else if (pend_r && !wact_r && (cmd_r != `CMD_READ || locked))
            begin
                pend_r <= 1'b0;
                go_r   <= cmd_r;
                wact_r <= cmd_r == `CMD_WRITE;
                beat_r <= 3'h0;
                // loop reset starts lock wait, see RQ20 see RQ21
                if (cmd_r == `CMD_MRS && addr_r[18:16] == `MW_SEL_FIRST &&
                    addr_r[`MW_DLLRST_BIT])
                    lock_r <= 16'(`LOOP_LOCK_CYC);
            end
            if (wact_r)
            begin
                dq_r   <= wdata_r[8*beat_r[1:0] +: 8] ^ {5'h0, beat_r};
                beat_r <= beat_r + 3'h1;
                wact_r <= beat_r != 3'h7;
            end
            // beat data lags launch by one cycle, so does its enable
            oe_r <= wact_r;
            if (link.dq_dev_oe)
                rdata_r <= {rdata_r[23:0], link.dq_dev};
        end
    end
endmodule : sdram_host

// [sdram_link_monitor.sv]
// concurrent checks on the link between controller and sdram model
`timescale 1ns/1ns
`include "mode_word_regs.svh"
module sdram_link_monitor
(
    input wire logic            pclk,
    input wire logic            presetn,
    input sdram_pkg::link_cmd_e cmd,
    input wire logic [15:0]     addr,
    input wire logic [2:0]      sel,
    input wire logic            dq_ctl_oe,
    input wire logic            dq_dev_oe
);
    int lock_cnt;
    wire is_mrs = cmd == sdram_pkg::CMD_MRS && sel == `MW_SEL_FIRST;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // =========================================
    // loop lock tracking, with two cycles of slack
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            lock_cnt <= 0;
        else if (is_mrs && addr[`MW_DLLRST_BIT])
            lock_cnt <= `LOOP_LOCK_CYC - 2;
        else if (lock_cnt > 0)
            lock_cnt <= lock_cnt - 1;
    // =========================================
    // link properties
    sequence s_rd;
        cmd == sdram_pkg::CMD_READ;
    endsequence
    property p_pulse;
        cmd != sdram_pkg::CMD_NOP |=> cmd == sdram_pkg::CMD_NOP;
    endproperty
    a_pulse: assert property (p_pulse) else $error("command wider than one cycle");
    property p_rd_lat;
        s_rd |-> ##[9:26] $rose(dq_dev_oe);
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    property p_rd_early;
        s_rd |=> (!$rose(dq_dev_oe))[*8];
    endproperty
    a_rd_early: assert property (p_rd_early) else $error("read data early");
    property p_burst;
        $rose(dq_dev_oe) |-> dq_dev_oe[*4];
    endproperty
    a_burst: assert property (p_burst) else $error("read burst cut short");
    property p_tm;
        is_mrs |-> !addr[`MW_TM_BIT];
    endproperty
    a_tm: assert property (p_tm) else $error("test mode bit set");
    property p_lock;
        s_rd |-> lock_cnt == 0;
    endproperty
    a_lock: assert property (p_lock) else $error("read during loop lock");
    property p_wr;
        cmd == sdram_pkg::CMD_WRITE |=> dq_ctl_oe[*4];
    endproperty
    a_wr: assert property (p_wr) else $error("write beats missing");
    property p_ctl_src;
        $rose(dq_ctl_oe) |-> $past(cmd) == sdram_pkg::CMD_WRITE;
    endproperty
    a_ctl_src: assert property (p_ctl_src) else $error("write beats without write");
endmodule : sdram_link_monitor

// [sdram_burst_order_latency_mode_bench.sv]
// self-checking bench joining controller and sdram model
`timescale 1ns/1ns
`include "mode_word_regs.svh"
module sdram_burst_order_latency_mode_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        apb_err;
    logic        crc_en;
    logic        mask_en;
    logic        write_blocked;
    logic [15:0] mode_word;
    logic [7:0]  wr_commit_delay;
    logic [7:0]  act_delay;
    logic [2:0]  write_start_pull;
    logic [7:0]  rec [8];
    int          fails;
    int          total_checks;
    sdram_link_if link ();
    // =========================================
    // design ends and checker
    sdram_host sdram_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    sdram_device sdram_device_i (.pclk(pclk), .presetn(presetn), .link(link), .crc_en(crc_en),
        .mask_en(mask_en), .mode_word(mode_word), .wr_commit_delay(wr_commit_delay),
        .act_delay(act_delay), .write_start_pull(write_start_pull),
        .write_blocked(write_blocked));
    sdram_link_monitor sdram_link_monitor_i (.pclk(pclk), .presetn(presetn), .cmd(link.cmd),
        .addr(link.addr), .sel(link.sel), .dq_ctl_oe(link.dq_ctl_oe),
        .dq_dev_oe(link.dq_dev_oe));
    // clock
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // =========================================
    // shared tasks
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic expire(input int n, input int lim);
        if (n >= lim)
        begin
            fails++;
            close_out();
        end
    endtask : expire
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        r = prdata;
        apb_err = pslverr;
        expire(n, 50);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic issue(input logic [2:0] s, input logic [15:0] a, input logic [2:0] c);
        logic [31:0] r;
        apb(1'b1, `CTL_ADDR_OFF, {13'h0, s, a}, r);
        apb(1'b1, `CTL_CMD_OFF, {29'h0, c}, r);
    endtask : issue
    task automatic mrs(input logic [15:0] w);
        issue(`MW_SEL_FIRST, w, `CMD_MRS);
        repeat (2) @(posedge pclk);
    endtask : mrs
    // =========================================
    // scenarios
    task automatic s_lock;
        logic [31:0] r;
        int n;
        mrs(16'h0180);
        n = 0;
        do
        begin
            apb(1'b0, `CTL_STAT_OFF, 32'h0, r);
            n++;
        end
        while (r[1] !== 1'b0 && n < 900);
        expire(n, 900);
        chk("test_mode_bit", 0, mode_word[7]);
        chk("loop_reset_bit", 0, mode_word[8]);
        apb(1'b0, 12'h100, 32'h0, r);
        chk("pslverr", 1, apb_err);
    endtask : s_lock
    task automatic s_fields;
        int wrv [7] = '{10, 12, 14, 16, 18, 20, 24};
        for (int k = 0; k < 7; k++)
        begin
            mrs(16'(k) << 9);
            chk("wr_field", k, mode_word[11:9]);
            chk("wr_commit_delay", wrv[k] + `TRP_CYC, wr_commit_delay);
            chk("act_delay", wrv[k] / 2 + `TRP_CYC, act_delay);
        end
        issue(3'h1, 16'h0002, `CMD_MRS);
        repeat (2) @(posedge pclk);
        chk("other_word", 16'h0C00, mode_word);
        crc_en <= 1'b1;
        mask_en <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("crc_commit_delay", 24 + `TRP_CYC + 2, wr_commit_delay);
        crc_en <= 1'b0;
        mask_en <= 1'b0;
        mrs({14'h0, `BL_CHOP});
        chk("chop_pull", `CHOP_PULL_IN, write_start_pull);
        mrs({14'h0, `BL_PER_CMD});
        chk("per_cmd_pull", 0, write_start_pull);
    endtask : s_fields
    task automatic rd_burst(input logic [2:0] s, input logic il, input logic ch);
        int n;
        logic [2:0] ix;
        logic [31:0] e;
        logic [31:0] r;
        e = 32'h0;
        issue(3'h7, {3'h0, ~ch, 6'h0, 3'h1, s}, `CMD_READ);
        n = 0;
        while (link.cmd !== sdram_pkg::CMD_READ && n < 10)
        begin
            @(posedge pclk);
            n++;
        end
        expire(n, 10);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (link.dq_dev_oe !== 1'b1 && n < 40);
        expire(n, 40);
        chk("read_delay", 9 + `AL_DEFAULT + 1, n);
        for (int j = 0; j < 8; j++)
        begin
            ix = il ? s ^ 3'(j) : {s[2] ^ (j > 3), s[1:0] + 2'(j)};
            if (ch && j > 3)
                chk("chop_tail_oe", 0, {link.dq_dev_oe, link.dqs_dev});
            else
            begin
                chk("beat", rec[ix], link.dq_dev);
                e = {e[23:0], rec[ix]};
            end
            @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
        apb(1'b0, `CTL_RDATA_OFF, 32'h0, r);
        chk("read_word", e, r);
    endtask : rd_burst
    task automatic s_order;
        logic [31:0] r;
        int n;
        mrs({14'h0, `BL_EIGHT});
        apb(1'b1, `CTL_WDATA_OFF, 32'h8C4A_E217, r);
        issue(3'h7, 16'h100B, `CMD_WRITE);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (link.dq_ctl_oe !== 1'b1 && n < 20);
        expire(n, 20);
        for (int j = 0; j < 8; j++)
        begin
            rec[j] = link.dq_ctl;
            @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        chk("write_blocked", 0, write_blocked);
        crc_en <= 1'b1;
        apb(1'b1, `CTL_WDATA_OFF, 32'h0, r);
        apb(1'b1, `CTL_CMD_OFF, {28'h0, 1'b1, `CMD_WRITE}, r);
        repeat (14) @(posedge pclk);
        chk("write_blocked_bad", 1, write_blocked);
        crc_en <= 1'b0;
        for (int m = 0; m < 16; m++)
        begin
            mrs({12'h0, m[3], 3'h0});
            rd_burst(m[2:0], m[3], 1'b0);
        end
        mrs({14'h0, `BL_CHOP});
        rd_burst(3'h5, 1'b0, 1'b1);
        mrs({14'h0, `BL_PER_CMD} | 16'h0008);
        rd_burst(3'h6, 1'b1, 1'b1);
        rd_burst(3'h2, 1'b1, 1'b0);
    endtask : s_order
    // =========================================
    // main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        crc_en = 1'b0;
        mask_en = 1'b0;
        fails = 0;
        total_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset_word", `MW_RESET, mode_word);
        s_lock();
        s_fields();
        s_order();
        close_out();
    end
endmodule : sdram_burst_order_latency_mode_bench
